/* design/sfdprom_rom.sv */
// Parameter table byte server: host starts a read at an address, then pulls bytes.
// Assumes the command decoder sits on sys_clk and issues start/advance strobes.
`timescale 1ns/1ps
`include "sfdprom_defs.svh"

// Notes on behaviour
// - Parameter-read command 5AH returns the stored table byte at each address.
// - Wait-state count zero means dummy clocks unsupported; nonzero gives the count.
// - Byte 38H bits 4:0 report four dummy clocks for quad-address quad-data read.
// - Byte 38H mode bits report 010b so the byte reads 44H.
// - Byte 39H returns opcode EBH for quad-address quad-data read.
// - Single-address quad-data descriptor reports eight dummy clocks, no mode bits: 08H.
// - Byte 3BH returns opcode 6BH for single-address quad-data read.
// - Single-address dual-data descriptor reports eight dummy clocks, no mode bits: 08H.
// - Byte 3DH returns opcode 3BH for single-address dual-data read.
// - Byte 3EH reports two dummy clocks and 010b mode bits: 42H.
// - Byte 3FH returns opcode BBH for dual-address dual-data read.
// - Byte 40H returns FEH: all-dual unsupported, all-quad supported.
// - All-dual descriptor reads 00H and its opcode byte 47H reads FFH.
// - Byte 4AH reports four dummy clocks and 010b mode bits: 44H.
// - Byte 4BH returns opcode EBH for all-quad read.
// - Sector size field is exponent N, 2^N bytes; zero means absent.
// - Sector type one: size 0CH at 4CH, erase opcode 20H at 4DH.
// - Sector type two: size 0FH, erase opcode 52H at 4FH.
// - Sector type three: size 10H, erase opcode D8H at 51H.
// - Sector type four absent: size 00H, opcode at 53H reads FFH.
module sfdprom_rom #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clkEn,
    // Host request
    input  wire logic [7:0]                 cmdCode,
    input  sfdprom_pkg::sfdprom_req_s       hostReq,
    input  wire logic                       readEnd,
    // Answer
    output logic                            dataValid,
    output sfdprom_pkg::sfdprom_byte_t      dataByte,
    output logic [ADDR_W-1:0]               curAddr,
    output logic                            busy
);

    sfdprom_pkg::sfdprom_state_e state_ff;
    logic [ADDR_W-1:0]           addr_ff;
    logic [ADDR_W-1:0]           tblAddr;
    logic                        fetch_ff;
    logic                        dataValid_ff;
    logic                        busy_ff;
    logic                        accept;
    logic                        step;
    sfdprom_pkg::sfdprom_byte_t  tblData;

    // Start only with the parameter-read opcode; other commands belong elsewhere
    assign accept = hostReq.start && (cmdCode == `SFDPROM_CMD_READ);
    assign step   = hostReq.advance && (state_ff == sfdprom_pkg::SFDPROM_BUSY);

    // Table is addressed with the next address so the byte lands one cycle later
    always_comb begin
        if (accept) begin
            tblAddr = hostReq.addr[ADDR_W-1:0];
        end else if (step) begin
            tblAddr = ADDR_W'(addr_ff + 1'b1);
        end else begin
            tblAddr = addr_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= sfdprom_pkg::SFDPROM_IDLE;
        end else if (clkEn) begin
            case (state_ff)
                sfdprom_pkg::SFDPROM_IDLE: begin
                    if (accept) begin
                        state_ff <= sfdprom_pkg::SFDPROM_BUSY;
                    end
                end
                sfdprom_pkg::SFDPROM_BUSY: begin
                    if (readEnd && !accept) begin
                        state_ff <= sfdprom_pkg::SFDPROM_IDLE;
                    end
                end
                default: state_ff <= sfdprom_pkg::SFDPROM_IDLE;
            endcase
        end
    end

    // Busy kept in its own flop so the output is not decoded from the state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
        end else if (clkEn) begin
            if (accept) begin
                busy_ff <= 1'b1;
            end else if (readEnd) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_ff <= '0;
        end else if (clkEn) begin
            addr_ff <= tblAddr;
        end
    end

    // Wrap past FFH is harmless: every byte outside the covered range reads FFH
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fetch_ff     <= 1'b0;
            dataValid_ff <= 1'b0;
        end else if (clkEn) begin
            fetch_ff     <= accept || step;
            dataValid_ff <= fetch_ff;
        end
    end

    sfdprom_table #(
        .ADDR_W (ADDR_W)
    ) u_table (
        .sys_clk (sys_clk),
        .clkEn   (clkEn),
        .rdAddr  (tblAddr),
        .rdData  (tblData)
    );

    // Output register holds the last byte so the host can sample at leisure
    sfdprom_pkg::sfdprom_byte_t dataByte_ff;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dataByte_ff <= `SFDPROM_FILL;
        end else if (clkEn && fetch_ff) begin
            dataByte_ff <= tblData;
        end
    end

    assign dataValid = dataValid_ff;
    assign dataByte  = dataByte_ff;
    assign curAddr   = addr_ff;
    assign busy      = busy_ff;

    // Reference address for the byte now in dataByte
    logic [ADDR_W-1:0] fetchAddr_ff;
    logic [ADDR_W-1:0] shownAddr_ff;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fetchAddr_ff <= '0;
            shownAddr_ff <= '0;
        end else if (clkEn) begin
            fetchAddr_ff <= tblAddr;
            if (fetch_ff) begin
                shownAddr_ff <= fetchAddr_ff;
            end
        end
    end

    chk_desc_38: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h38) |-> dataByte == 8'h44)
        else $error("Byte 38H not 44H");
    chk_wait_38: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h38) |-> dataByte[4:0] == 5'h04)
        else $error("Byte 38H wait count wrong");
    chk_opc_39: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h39) |-> dataByte == 8'heb)
        else $error("Byte 39H not EBH");
    chk_desc_3a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h3a) |-> dataByte == 8'h08)
        else $error("Byte 3AH not 08H");
    chk_opc_3b: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h3b) |-> dataByte == 8'h6b)
        else $error("Byte 3BH not 6BH");
    chk_desc_3c: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h3c) |-> dataByte == 8'h08)
        else $error("Byte 3CH not 08H");
    chk_opc_3d: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h3d) |-> dataByte == 8'h3b)
        else $error("Byte 3DH not 3BH");
    chk_desc_3e: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h3e) |-> dataByte == 8'h42)
        else $error("Byte 3EH not 42H");
    chk_opc_3f: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h3f) |-> dataByte == 8'hbb)
        else $error("Byte 3FH not BBH");
    chk_mode_40: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h40) |-> dataByte == 8'hfe)
        else $error("Byte 40H not FEH");
    chk_all_dual: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h47) |-> dataByte == 8'hff)
        else $error("Byte 47H not FFH");
    chk_desc_4a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h4a) |-> dataByte == 8'h44)
        else $error("Byte 4AH not 44H");
    chk_opc_4b: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h4b) |-> dataByte == 8'heb)
        else $error("Byte 4BH not EBH");
    chk_sector_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h4d) |-> dataByte == 8'h20)
        else $error("Byte 4DH not 20H");
    chk_sector_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h4f) |-> dataByte == 8'h52)
        else $error("Byte 4FH not 52H");
    chk_sector_three: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h51) |-> dataByte == 8'hd8)
        else $error("Byte 51H not D8H");
    chk_sector_four: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h52) |-> dataByte == 8'h00)
        else $error("Byte 52H not 00H");
    chk_sector_one_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h4c) |-> dataByte == 8'h0c)
        else $error("Byte 4CH not 0CH");
    chk_sector_two_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h4e) |-> dataByte == 8'h0f)
        else $error("Byte 4EH not 0FH");
    chk_sector_four_opc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h53) |-> dataByte == 8'hff)
        else $error("Byte 53H not FFH");
    chk_dual_desc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h46) |-> dataByte == 8'h00)
        else $error("Byte 46H not 00H");
    chk_density_msb: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h37) |-> dataByte == 8'h03)
        else $error("Density high byte wrong");
    chk_busy_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy == (state_ff == sfdprom_pkg::SFDPROM_BUSY))
        else $error("Busy flag out of step with state");
    chk_sector_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h50) |-> dataByte == 8'h10)
        else $error("Byte 50H not 10H");
    chk_density_lsb: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h34) |-> dataByte == 8'hff)
        else $error("Density low byte wrong");
    chk_unused_fill: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h41) |-> dataByte == 8'hff)
        else $error("Unused byte not FFH");
    chk_wait_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataValid && shownAddr_ff == ADDR_W'(8'h46) |-> dataByte[4:0] == 5'h00)
        else $error("Unsupported mode wait count not zero");
    chk_addr_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && step && !accept |=> curAddr == ADDR_W'($past(curAddr) + 1'b1))
        else $error("Address did not advance");
    chk_read_lat: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && accept ##1 clkEn |=> dataValid)
        else $error("No byte two cycles after start");

    cov_start: cover property (@(posedge sys_clk) disable iff (!rst_n) accept);
    cov_burst: cover property (@(posedge sys_clk) disable iff (!rst_n)
        accept ##1 step ##1 step ##1 step);
    cov_end:   cover property (@(posedge sys_clk) disable iff (!rst_n) busy ##1 !busy);

endmodule : sfdprom_rom

/* design/sfdprom_defs.svh */
// Constants for the parameter table byte store: address range, byte values, field positions.
// Assumes inclusion by name from design files that need the table contents.
`ifndef SFDPROM_DEFS_SVH
`define SFDPROM_DEFS_SVH

`define SFDPROM_CMD_READ        8'h5a
`define SFDPROM_ADDR_FIRST      8'h34
`define SFDPROM_ADDR_LAST       8'h53
`define SFDPROM_FILL            8'hff
`define SFDPROM_WAIT_LSB        0
`define SFDPROM_WAIT_MSB        4
`define SFDPROM_MODE_LSB        5
`define SFDPROM_MODE_MSB        7
`define SFDPROM_DENSITY         32'h03ffffff
`define SFDPROM_Q44_WAIT        5'h04
`define SFDPROM_Q44_MODE        3'h2
`define SFDPROM_Q44_OPC         8'heb
`define SFDPROM_Q14_WAIT        5'h08
`define SFDPROM_Q14_MODE        3'h0
`define SFDPROM_Q14_OPC         8'h6b
`define SFDPROM_D12_WAIT        5'h08
`define SFDPROM_D12_MODE        3'h0
`define SFDPROM_D12_OPC         8'h3b
`define SFDPROM_D22_WAIT        5'h02
`define SFDPROM_D22_MODE        3'h2
`define SFDPROM_D22_OPC         8'hbb
`define SFDPROM_ALLMODE_SUPPORT 8'hfe
`define SFDPROM_A2_DESC         8'h00
`define SFDPROM_A2_OPC          8'hff
`define SFDPROM_A4_WAIT         5'h04
`define SFDPROM_A4_MODE         3'h2
`define SFDPROM_A4_OPC          8'heb
`define SFDPROM_SEC1_SIZE       8'h0c
`define SFDPROM_SEC1_OPC        8'h20
`define SFDPROM_SEC2_SIZE       8'h0f
`define SFDPROM_SEC2_OPC        8'h52
`define SFDPROM_SEC3_SIZE       8'h10
`define SFDPROM_SEC3_OPC        8'hd8
`define SFDPROM_SEC4_SIZE       8'h00
`define SFDPROM_SEC4_OPC        8'hff

`endif

/* design/sfdprom_pkg.sv */
// Types shared by the parameter table store.
// Assumes the constants header provides the values.
package sfdprom_pkg;

    typedef logic [7:0] sfdprom_byte_t;

    // Fast-read descriptor byte: mode bits above wait-state count
    typedef struct packed {
        logic [2:0] modeBits;
        logic [4:0] waitClocks;
    } sfdprom_desc_s;

    // Host request: start strobe with address, then advance strobes
    typedef struct packed {
        logic          start;
        logic          advance;
        sfdprom_byte_t addr;
    } sfdprom_req_s;

    typedef enum logic [1:0] {
        SFDPROM_IDLE = 2'b01,
        SFDPROM_BUSY = 2'b10
    } sfdprom_state_e;

endpackage : sfdprom_pkg

/* design/sfdprom_table.sv */
// Byte table memory covering table addresses 34H..53H, registered read.
// Assumes a synchronous caller on sys_clk; read data follow one cycle after the address.
`timescale 1ns/1ps
`include "sfdprom_defs.svh"

module sfdprom_table #(
    parameter int ADDR_W = 8
) (
    // Clock
    input  wire logic                       sys_clk,
    input  wire logic                       clkEn,
    // Read port
    input  wire logic [ADDR_W-1:0]          rdAddr,
    output sfdprom_pkg::sfdprom_byte_t      rdData
);

    localparam logic [31:0] DENSITY = `SFDPROM_DENSITY;

    function automatic sfdprom_pkg::sfdprom_byte_t desc(input logic [2:0] mb, input logic [4:0] wc);
        sfdprom_pkg::sfdprom_desc_s d;
        d.modeBits   = mb;
        d.waitClocks = wc;
        return d;
    endfunction : desc

    sfdprom_pkg::sfdprom_byte_t nxtData;
    sfdprom_pkg::sfdprom_byte_t rdData_ff;

    always_comb begin
        case (rdAddr[7:0])
            8'h34: nxtData = DENSITY[7:0];
            8'h35: nxtData = DENSITY[15:8];
            8'h36: nxtData = DENSITY[23:16];
            8'h37: nxtData = DENSITY[31:24];
            8'h38: nxtData = desc(`SFDPROM_Q44_MODE, `SFDPROM_Q44_WAIT);
            8'h39: nxtData = `SFDPROM_Q44_OPC;
            8'h3a: nxtData = desc(`SFDPROM_Q14_MODE, `SFDPROM_Q14_WAIT);
            8'h3b: nxtData = `SFDPROM_Q14_OPC;
            8'h3c: nxtData = desc(`SFDPROM_D12_MODE, `SFDPROM_D12_WAIT);
            8'h3d: nxtData = `SFDPROM_D12_OPC;
            8'h3e: nxtData = desc(`SFDPROM_D22_MODE, `SFDPROM_D22_WAIT);
            8'h3f: nxtData = `SFDPROM_D22_OPC;
            8'h40: nxtData = `SFDPROM_ALLMODE_SUPPORT;
            8'h46: nxtData = `SFDPROM_A2_DESC;
            8'h47: nxtData = `SFDPROM_A2_OPC;
            8'h4a: nxtData = desc(`SFDPROM_A4_MODE, `SFDPROM_A4_WAIT);
            8'h4b: nxtData = `SFDPROM_A4_OPC;
            8'h4c: nxtData = `SFDPROM_SEC1_SIZE;
            8'h4d: nxtData = `SFDPROM_SEC1_OPC;
            8'h4e: nxtData = `SFDPROM_SEC2_SIZE;
            8'h4f: nxtData = `SFDPROM_SEC2_OPC;
            8'h50: nxtData = `SFDPROM_SEC3_SIZE;
            8'h51: nxtData = `SFDPROM_SEC3_OPC;
            8'h52: nxtData = `SFDPROM_SEC4_SIZE;
            8'h53: nxtData = `SFDPROM_SEC4_OPC;
            default: nxtData = `SFDPROM_FILL;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            rdData_ff <= nxtData;
        end
    end

    assign rdData = rdData_ff;

endmodule : sfdprom_table

/* testbench/sfdprom_host.sv */
// Host controller model: issues parameter reads as start/advance strobes and collects returned bytes.
// Assumes the byte server's answer arrives a fixed count of enabled cycles after each request.
`timescale 1ns/1ps

module sfdprom_host (
    // Clock
    input  wire logic                          sys_clk,
    // Requests
    output logic                               clkEn,
    output logic [7:0]                         cmdCode,
    output sfdprom_pkg::sfdprom_req_s          hostReq,
    output logic                               readEnd,
    // Answer
    input  wire logic                          dataValid,
    input  wire sfdprom_pkg::sfdprom_byte_t    dataByte,
    input  wire logic                          busy
);
    initial begin
        clkEn   = 1'b1;
        cmdCode = 8'h00;
        hostReq = '0;
        readEnd = 1'b0;
    end

    // Clock enable drops for two edges at stallAt, holding the pending request
    task automatic burst(input logic [7:0] cmd, input logic [7:0] a, input int n, input logic withStart,
                         input int stallAt, output sfdprom_pkg::sfdprom_byte_t got[$], output int firstAt,
                         output logic busyMid);
        int   k;
        int   req;
        logic enPrev;
        got     = {};
        firstAt = -1;
        req     = 0;
        enPrev  = 1'b1;
        busyMid = 1'b0;
        for (k = 0; k < n + 12; k++) begin
            @(negedge sys_clk);
            // Only count a byte that followed an enabled edge; a frozen strobe is not new data
            if (enPrev && dataValid === 1'b1) begin
                if (got.size() == 0) firstAt = k;
                got.push_back(dataByte);
            end
            if (k == 1) busyMid = busy;
            if (got.size() >= n || k == n + 11) break;
            enPrev          = (k != stallAt) && (k != stallAt + 1);
            clkEn           = enPrev;
            cmdCode         = cmd;
            hostReq.start   = withStart && (req == 0);
            hostReq.advance = (req > 0 || !withStart) && (req < n);
            hostReq.addr    = a;
            if (enPrev && req < n) req++;
        end
        // Idle command lines show the inverse of the last value, not a stale copy
        clkEn   = 1'b1;
        hostReq = '0;
        cmdCode = ~cmd;
        readEnd = 1'b1;
        @(negedge sys_clk);
        readEnd = 1'b0;
    endtask : burst
endmodule : sfdprom_host

/* testbench/tb_top.sv */
// Self-checking bench for the parameter table byte server.
// Assumes the host model drives all requests at the falling clock edge.
`timescale 1ns/1ps

module tb_top;
    logic                       sys_clk;
    logic                       rst_n;
    logic                       clkEn;
    logic                       readEnd;
    logic                       dataValid;
    logic                       busy;
    logic [7:0]                 cmdCode;
    logic [7:0]                 curAddr;
    sfdprom_pkg::sfdprom_req_s  hostReq;
    sfdprom_pkg::sfdprom_byte_t dataByte;
    sfdprom_pkg::sfdprom_byte_t got[$];
    int                         err_total;
    int                         checks_done;
    int                         cycles;
    int                         firstAt;
    int                         i;
    logic                       busyMid;
    logic [7:0]                 badCmd[4] = '{8'h03, 8'h0b, 8'h5b, 8'ha5};

    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    sfdprom_rom #(.ADDR_W(8)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .cmdCode(cmdCode), .hostReq(hostReq),
        .readEnd(readEnd), .dataValid(dataValid), .dataByte(dataByte), .curAddr(curAddr), .busy(busy)
    );

    sfdprom_host i_host (
        .sys_clk(sys_clk), .clkEn(clkEn), .cmdCode(cmdCode), .hostReq(hostReq), .readEnd(readEnd),
        .dataValid(dataValid), .dataByte(dataByte), .busy(busy)
    );

    function automatic logic [7:0] expByte(input logic [7:0] a);
        case (a)
            8'h34, 8'h35, 8'h36: expByte = 8'hff;
            8'h37: expByte = 8'h03;
            8'h38: expByte = 8'h44;
            8'h39: expByte = 8'heb;
            8'h3a: expByte = 8'h08;
            8'h3b: expByte = 8'h6b;
            8'h3c: expByte = 8'h08;
            8'h3d: expByte = 8'h3b;
            8'h3e: expByte = 8'h42;
            8'h3f: expByte = 8'hbb;
            8'h40: expByte = 8'hfe;
            8'h46: expByte = 8'h00;
            8'h4a: expByte = 8'h44;
            8'h4b: expByte = 8'heb;
            8'h4c: expByte = 8'h0c;
            8'h4d: expByte = 8'h20;
            8'h4e: expByte = 8'h0f;
            8'h4f: expByte = 8'h52;
            8'h50: expByte = 8'h10;
            8'h51: expByte = 8'hd8;
            8'h52: expByte = 8'h00;
            default: expByte = 8'hff;
        endcase
    endfunction : expByte

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chkByte(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chkByte

    task automatic chkFlag(input logic g, input logic e);
        chkByte({7'h00, g}, {7'h00, e});
    endtask : chkFlag

    task automatic chkNum(input int g, input int e);
        checks_done++;
        if (g != e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chkNum

    // Compares a whole burst against the table, starting at address a
    task automatic chkBurst(input logic [7:0] a, input int n);
        chkNum(got.size(), n);
        for (int j = 0; j < got.size(); j++) begin
            chkByte(got[j], expByte(8'(a + j)));
        end
    endtask : chkBurst

    task automatic endTest(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask : endTest

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        rst_n       = 1'b0;
        err_total   = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (8) @(negedge sys_clk);
        chkFlag(dataValid, 1'b0);
        chkByte(dataByte, 8'hff);
        chkByte(curAddr, 8'h00);
        chkFlag(busy, 1'b0);
        rst_n = 1'b1;
        endTest("reset");

        i_host.burst(8'h5a, 8'h30, 39, 1'b1, -5, got, firstAt, busyMid);
        chkBurst(8'h30, 39);
        chkNum(firstAt, 2);
        chkFlag(busyMid, 1'b1);
        chkByte(curAddr, 8'h56);
        chkFlag(busy, 1'b0);
        endTest("sweep");

        for (i = 8'h38; i <= 8'h53; i++) begin
            i_host.burst(8'h5a, 8'(i), 1, 1'b1, -5, got, firstAt, busyMid);
            chkBurst(8'(i), 1);
            chkNum(firstAt, 2);
        end
        endTest("single");

        i_host.burst(8'h5a, 8'hfe, 4, 1'b1, -5, got, firstAt, busyMid);
        chkBurst(8'hfe, 4);
        chkByte(curAddr, 8'h01);
        endTest("wrap");

        i_host.burst(8'h5a, 8'h4a, 10, 1'b1, 3, got, firstAt, busyMid);
        chkBurst(8'h4a, 10);
        endTest("stall");

        for (i = 0; i < 4; i++) begin
            i_host.burst(badCmd[i], 8'h38, 1, 1'b1, -5, got, firstAt, busyMid);
            chkNum(got.size(), 0);
            chkFlag(busyMid, 1'b0);
        end
        i_host.burst(8'h5a, 8'h38, 1, 1'b0, -5, got, firstAt, busyMid);
        chkNum(got.size(), 0);
        chkFlag(busyMid, 1'b0);
        endTest("refused");

        conclude();
    end
endmodule : tb_top
